// ### rtl/iom_regs.vh
/*
 * constants of the interpolator output-stage logic: register offsets,
 * field positions, reset values, mode codes and timing counts.
 * assumes it is included by bare name from files under rtl/.
 */
`ifndef IOM_REGS_VH
`define IOM_REGS_VH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define IOM_ADDR_W 8
`define IOM_OFS_MODE 8'h00
`define IOM_OFS_CFG 8'h04
`define IOM_OFS_STAT 8'h08
`define IOM_OFS_MASK 8'h0C
`define IOM_OFS_STATE 8'h10

// ----------------------------------------------------------------
// mode codes
// ----------------------------------------------------------------
`define IOM_MODE_QUAD 4'h0
`define IOM_MODE_CAL1 4'h1
`define IOM_MODE_CAL2 4'h2
`define IOM_MODE_TEST5 4'h5
`define IOM_MODE_TEST6 4'h6
`define IOM_MODE_CAL3 4'h7
`define IOM_MODE_SYST 4'hB
`define IOM_MODE_CNT 4'hF
`define IOM_MODE_RST 4'h0

// ----------------------------------------------------------------
// cfg register fields
// ----------------------------------------------------------------
`define IOM_CFG_OFSSEL_LO 0
`define IOM_CFG_OFSSEL_HI 1
`define IOM_CFG_PHD_LO 4
`define IOM_CFG_PHD_HI 7
`define IOM_CFG_RST 32'h0000_0010
`define IOM_OFSSEL_MID 2'h3

// ----------------------------------------------------------------
// status bits: index seen, count pulse, line-count error
// ----------------------------------------------------------------
`define IOM_ST_INDEX 0
`define IOM_ST_COUNT 1
`define IOM_ST_LCERR 2
`define IOM_ST_W 3

// ----------------------------------------------------------------
// timing: count pulse unit time in ns, cycles per unit at 200 MHz
// ----------------------------------------------------------------
`define IOM_CLK_NS 5
`define IOM_PHD_UNIT_NS 25
`define IOM_PHD_UNIT_CYC ((`IOM_PHD_UNIT_NS + `IOM_CLK_NS - 1) / `IOM_CLK_NS)

`endif

// ### rtl/iom_sync.v
/*
 * two-stage synchroniser for a bus of asynchronous levels.
 * assumes the inputs come from pins or another clock domain.
 */
`timescale 1ns/1ps
module iom_sync #(
    parameter W = 1
) (
    input wire sys_clk,
    input wire rst_b,
    input wire [W-1:0] async_in,
    output reg [W-1:0] sync_out
);

    reg [W-1:0] meta_r;

    // -------------------------------------------------------------
    // first stage feeds only the second stage
    // -------------------------------------------------------------
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_r <= {W{1'b0}};
            sync_out <= {W{1'b0}};
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule

// ### rtl/iom_top.v
/*
 * output-stage logic of a sine/cosine interpolator: routes position,
 * counter-control and diagnostic signals onto three pin pairs plus a
 * fault pin, by operating mode, with a small register port.
 * assumes step/direction, index and comparator inputs come from the
 * interpolator core (possibly another clock, hence synchronised), and
 * analog routings are only reported as select codes to the pad ring.
 */
// How it works
// - mode register 4-bit field; 0 quadrature, F counter, B system test.
// - line drivers and polarity protection enabled only in modes 0 and F.
// - counter mode: down clock on A true, up on A comp, common on B true.
// - counter mode: B comp carries direction, 0 up, 1 down.
// - counter mode: index true pin high while index reached, else low.
// - counter mode: index comp pin low while index reached, else high.
// - count clocks are low pulses whose length follows min phase distance.
// - calibration 2 outputs reduced sine/cosine; midpoints only if select 3.
// - calibration 3 presents temperature monitoring signals.
// - at resolution 8 a switching point every 45 degrees.
// - system test: comparators offset1, phase, offset2, amplitude on pins.
// - system test: raw unmasked index on index true pin.
// - system test: index comp low while line count verifies, then high.
// - fault reports line-count error only from second index, when enabled.
`timescale 1ns/1ps
`include "iom_regs.vh"
module iom_top #(
    parameter LINES_W = 16
) (
    input wire sys_clk,
    input wire rst_b,
    input wire [`IOM_ADDR_W-1:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    output wire irq,
    input wire step_up,
    input wire step_dn,
    input wire quad_a,
    input wire quad_b,
    input wire index_masked,
    input wire raw_index_signal,
    input wire index_enable,
    input wire [LINES_W-1:0] expected_lines,
    input wire offset_ch1_comparator,
    input wire phase_error_comparator,
    input wire offset_ch2_comparator,
    input wire amplitude_error_comparator,
    input wire fault_in,
    output reg line_a_true_pin,
    output reg line_a_comp_pin,
    output reg line_b_true_pin,
    output reg line_b_comp_pin,
    output reg line_index_true_pin,
    output reg line_index_comp_pin,
    output reg fault_pin,
    output reg driver_enable,
    output reg [3:0] analog_route_sel,
    output reg midpoint_route_en
);

    // -------------------------------------------------------------
    // input synchronisers
    // -------------------------------------------------------------
    wire [10:0] sync_w;
    wire s_up, s_dn, s_qa, s_qb, s_zm, s_zr, s_zen, s_c1, s_c2, s_c3, s_c4;

    iom_sync #(
        .W(11)
    ) u_sync (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .async_in({step_up, step_dn, quad_a, quad_b, index_masked, raw_index_signal,
            index_enable, offset_ch1_comparator, phase_error_comparator,
            offset_ch2_comparator, amplitude_error_comparator}),
        .sync_out(sync_w)
    );
    assign {s_up, s_dn, s_qa, s_qb, s_zm, s_zr, s_zen, s_c1, s_c2, s_c3, s_c4} = sync_w;

    // -------------------------------------------------------------
    // registers
    // -------------------------------------------------------------
    reg [3:0] mode_r;
    reg [31:0] cfg_r;
    reg [`IOM_ST_W-1:0] stat_r;
    reg [`IOM_ST_W-1:0] mask_r;
    reg [`IOM_ST_W-1:0] ev_w;

    wire [1:0] ofs_sel = cfg_r[`IOM_CFG_OFSSEL_HI:`IOM_CFG_OFSSEL_LO];
    wire [3:0] phd_sel = cfg_r[`IOM_CFG_PHD_HI:`IOM_CFG_PHD_LO];

    function sel;
        input [`IOM_ADDR_W-1:0] a;
        input [`IOM_ADDR_W-1:0] ofs;
        begin
            sel = (a == ofs);
        end
    endfunction

    // software writes: mode, cfg, mask; status clears by writing one
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_r <= `IOM_MODE_RST;
            cfg_r <= `IOM_CFG_RST;
            mask_r <= {`IOM_ST_W{1'b0}};
            stat_r <= {`IOM_ST_W{1'b0}};
        end else begin
            if (reg_wr && sel(reg_addr, `IOM_OFS_MODE)) begin
                mode_r <= reg_wdata[3:0];
            end
            if (reg_wr && sel(reg_addr, `IOM_OFS_CFG)) begin
                cfg_r <= reg_wdata;
            end
            if (reg_wr && sel(reg_addr, `IOM_OFS_MASK)) begin
                mask_r <= reg_wdata[`IOM_ST_W-1:0];
            end
            // a new event beats a clear in the same cycle
            if (reg_wr && sel(reg_addr, `IOM_OFS_STAT)) begin
                stat_r <= (stat_r & ~reg_wdata[`IOM_ST_W-1:0]) | ev_w;
            end else begin
                stat_r <= stat_r | ev_w;
            end
        end
    end

    // level interrupt, combinational so it drops in the cycle a clear lands
    assign irq = |(stat_r & mask_r);

    // -------------------------------------------------------------
    // read port: data stands one cycle after the strobe
    // -------------------------------------------------------------
    reg lc_done_r;
    reg lc_err_r;
    reg [1:0] idx_cnt_r;

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `IOM_OFS_MODE: reg_rdata <= {28'h000_0000, mode_r};
                `IOM_OFS_CFG: reg_rdata <= cfg_r;
                `IOM_OFS_STAT: reg_rdata <= {29'h000_0000, stat_r};
                `IOM_OFS_MASK: reg_rdata <= {29'h000_0000, mask_r};
                // state word: index count, error, done, driver enable, masked index
                `IOM_OFS_STATE: reg_rdata <= {26'h000_0000, idx_cnt_r, lc_err_r,
                    lc_done_r, driver_enable, s_zm};
                default: reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // -------------------------------------------------------------
    // count pulse generator: one low pulse per step
    // -------------------------------------------------------------
    // pulse length is (phd_sel+1) units; a new step arriving during a pulse
    // or the equal gap after it is dropped, so the core must keep steps farther apart than pulse plus gap
    localparam [1:0] CP_IDLE = 2'd0;
    localparam [1:0] CP_LOW = 2'd1;
    localparam [1:0] CP_GAP = 2'd2;
    reg [1:0] cp_st_r;
    reg [11:0] cp_cnt_r;
    reg up_d_r, dn_d_r;
    reg dir_r;
    reg cp_up_r, cp_dn_r;
    wire up_edge = s_up & ~up_d_r;
    wire dn_edge = s_dn & ~dn_d_r;
    // the product is 32 bits wide; a 4-bit select keeps it far below 12 bits
    wire [31:0] cp_len_full = ({28'h000_0000, phd_sel} + 32'h0000_0001) * `IOM_PHD_UNIT_CYC;
    wire [11:0] cp_len = cp_len_full[11:0];

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cp_st_r <= CP_IDLE;
            cp_cnt_r <= 12'h000;
            up_d_r <= 1'b0;
            dn_d_r <= 1'b0;
            dir_r <= 1'b0;
            cp_up_r <= 1'b0;
            cp_dn_r <= 1'b0;
        end else begin
            up_d_r <= s_up;
            dn_d_r <= s_dn;
            case (cp_st_r)
                CP_IDLE: begin
                    if (up_edge || dn_edge) begin
                        // up wins a tie, so the direction must follow the clock that fires
                        dir_r <= dn_edge & ~up_edge;
                        cp_up_r <= up_edge;
                        cp_dn_r <= dn_edge & ~up_edge;
                        cp_cnt_r <= cp_len;
                        cp_st_r <= CP_LOW;
                    end
                end
                CP_LOW: begin
                    if (cp_cnt_r <= 12'h001) begin
                        cp_up_r <= 1'b0;
                        cp_dn_r <= 1'b0;
                        cp_cnt_r <= cp_len;
                        cp_st_r <= CP_GAP;
                    end else begin
                        cp_cnt_r <= cp_cnt_r - 12'h001;
                    end
                end
                // hold the line quiet as long as the pulse, so edges stay apart
                CP_GAP: begin
                    if (cp_cnt_r <= 12'h001) begin
                        cp_st_r <= CP_IDLE;
                    end else begin
                        cp_cnt_r <= cp_cnt_r - 12'h001;
                    end
                end
                default: cp_st_r <= CP_IDLE;
            endcase
        end
    end

    // -------------------------------------------------------------
    // line-count verification between index pulses
    // -------------------------------------------------------------
    reg zr_d_r;
    reg [LINES_W-1:0] lines_r;
    wire zr_edge = s_zr & ~zr_d_r;
    wire step_any = (up_edge | dn_edge) & (cp_st_r == CP_IDLE);

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            zr_d_r <= 1'b0;
            lines_r <= {LINES_W{1'b0}};
            idx_cnt_r <= 2'd0;
            lc_done_r <= 1'b0;
            lc_err_r <= 1'b0;
        end else begin
            zr_d_r <= s_zr;
            if (zr_edge && s_zen) begin
                if (idx_cnt_r != 2'd2) begin
                    idx_cnt_r <= idx_cnt_r + 2'd1;
                end
                lines_r <= {LINES_W{1'b0}};
                // the first enabled index only opens the window; nothing to compare yet
                if (idx_cnt_r != 2'd0) begin
                    lc_done_r <= 1'b1;
                    lc_err_r <= (lines_r != expected_lines);
                end
            end else if (step_any) begin
                lines_r <= lines_r + {{(LINES_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // one-cycle event pulses that set the sticky status bits
    always @* begin
        ev_w = {`IOM_ST_W{1'b0}};
        ev_w[`IOM_ST_INDEX] = zr_edge;
        ev_w[`IOM_ST_COUNT] = step_any;
        ev_w[`IOM_ST_LCERR] = zr_edge & s_zen & (idx_cnt_r != 2'd0) &
            (lines_r != expected_lines);
    end

    // -------------------------------------------------------------
    // pin routing by mode, registered so the pins never glitch
    // -------------------------------------------------------------
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            line_a_true_pin <= 1'b0;
            line_a_comp_pin <= 1'b1;
            line_b_true_pin <= 1'b0;
            line_b_comp_pin <= 1'b1;
            line_index_true_pin <= 1'b0;
            line_index_comp_pin <= 1'b1;
            fault_pin <= 1'b0;
            driver_enable <= 1'b0;
            analog_route_sel <= 4'h0;
            midpoint_route_en <= 1'b0;
        end else begin
            driver_enable <= (mode_r == `IOM_MODE_QUAD) || (mode_r == `IOM_MODE_CNT);
            analog_route_sel <= mode_r;
            midpoint_route_en <= (mode_r == `IOM_MODE_CAL2) &&
                (ofs_sel == `IOM_OFSSEL_MID);
            case (mode_r)
                `IOM_MODE_QUAD: begin
                    // complementary pairs for the differential drivers
                    line_a_true_pin <= s_qa;
                    line_a_comp_pin <= ~s_qa;
                    line_b_true_pin <= s_qb;
                    line_b_comp_pin <= ~s_qb;
                    line_index_true_pin <= s_zm;
                    line_index_comp_pin <= ~s_zm;
                    fault_pin <= fault_in | lc_err_r;
                end
                `IOM_MODE_CNT: begin
                    // count clocks idle high; each count is the low phase
                    line_a_true_pin <= ~cp_dn_r;
                    line_a_comp_pin <= ~cp_up_r;
                    line_b_true_pin <= ~(cp_up_r | cp_dn_r);
                    line_b_comp_pin <= dir_r;
                    line_index_true_pin <= s_zm;
                    line_index_comp_pin <= ~s_zm;
                    fault_pin <= fault_in | lc_err_r;
                end
                `IOM_MODE_SYST: begin
                    // the comparators switch at the core's 45-degree points at resolution 8
                    line_a_true_pin <= s_c1;
                    line_a_comp_pin <= s_c2;
                    line_b_true_pin <= s_c3;
                    line_b_comp_pin <= s_c4;
                    line_index_true_pin <= s_zr;
                    line_index_comp_pin <= lc_done_r;
                    fault_pin <= lc_err_r;
                end
                `IOM_MODE_CAL3: begin
                    // temperature signals are analog; only the warning reaches the fault pin
                    line_a_true_pin <= 1'b0;
                    line_a_comp_pin <= 1'b0;
                    line_b_true_pin <= 1'b0;
                    line_b_comp_pin <= 1'b0;
                    line_index_true_pin <= 1'b0;
                    line_index_comp_pin <= 1'b0;
                    fault_pin <= fault_in;
                end
                default: begin
                    // analog routings: digital drive parked low
                    line_a_true_pin <= 1'b0;
                    line_a_comp_pin <= 1'b0;
                    line_b_true_pin <= 1'b0;
                    line_b_comp_pin <= 1'b0;
                    line_index_true_pin <= 1'b0;
                    line_index_comp_pin <= 1'b0;
                    fault_pin <= 1'b0;
                end
            endcase
        end
    end

endmodule

// ### tb/iom_chk_asserts.sv
/* checker of the interpolator output stage, bound to iom_top.
   assumes one clock, sys_clk, and async active-low rst_b. */
`timescale 1ns/1ps
`include "iom_regs.vh"
module iom_chk (
    input wire sys_clk,
    input wire rst_b,
    input wire reg_rd,
    input wire [31:0] reg_rdata,
    input wire offset_ch1_comparator,
    input wire amplitude_error_comparator,
    input wire raw_index_signal,
    input wire line_a_true_pin,
    input wire line_a_comp_pin,
    input wire line_b_true_pin,
    input wire line_b_comp_pin,
    input wire line_index_true_pin,
    input wire line_index_comp_pin,
    input wire driver_enable,
    input wire [3:0] analog_route_sel,
    input wire midpoint_route_en
);
    // --------------------------
    // qualifiers and sequences
    // --------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    wire cnt_m = analog_route_sel == `IOM_MODE_CNT;
    wire sys_m = analog_route_sel == `IOM_MODE_SYST;
    // three cycles in mode so the registered pins have caught up
    sequence in_cnt;
        cnt_m [*3];
    endsequence
    sequence low_pulse;
        (!line_b_true_pin) [*5];
    endsequence
    // --------------------------
    // pin relations
    // --------------------------
    a_drv_mode: assert property ($stable(analog_route_sel) [*4] |->
        driver_enable == (analog_route_sel == `IOM_MODE_QUAD || cnt_m))
        else $error("driver enable wrong for mode");
    a_one_dir: assert property (in_cnt |-> line_a_true_pin || line_a_comp_pin)
        else $error("up and down clocks low together");
    a_cp_pair: assert property (in_cnt |->
        line_b_true_pin == (line_a_true_pin && line_a_comp_pin))
        else $error("common clock not paired with up or down clock");
    a_dir_up: assert property (in_cnt ##0 $fell(line_a_comp_pin) |-> !line_b_comp_pin)
        else $error("up pulse without up direction");
    a_dir_down: assert property (in_cnt ##0 $fell(line_a_true_pin) |-> line_b_comp_pin)
        else $error("down pulse without down direction");
    a_pulse_min: assert property (in_cnt ##0 $fell(line_b_true_pin) |-> low_pulse)
        else $error("count pulse shorter than one unit");
    a_idx_pair: assert property (in_cnt |-> line_index_true_pin != line_index_comp_pin)
        else $error("clear and load strobes disagree");
    a_sys_ofs: assert property ((sys_m && offset_ch1_comparator) [*6] |-> line_a_true_pin)
        else $error("offset comparator not on a true pin");
    a_sys_amp: assert property ((sys_m && !amplitude_error_comparator) [*6] |->
        !line_b_comp_pin)
        else $error("amplitude comparator not on b comp pin");
    a_sys_raw: assert property ((sys_m && raw_index_signal) [*6] |-> line_index_true_pin)
        else $error("raw index not on index true pin");
    a_mid_route: assert property (midpoint_route_en |->
        analog_route_sel == `IOM_MODE_CAL2 || $past(analog_route_sel) == `IOM_MODE_CAL2)
        else $error("midpoints routed outside calibration 2");
    a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
        else $error("read data outside read cycle");
endmodule
bind iom_top iom_chk u_chk (.*);

// ### tb/iom_cnt_model.sv
/* behavioural external up/down counter fed by the counter-mode pins.
   assumes pins arrive as levels; load value is zero. */
`timescale 1ns/1ps
module iom_cnt_model (
    input wire count_clock,
    input wire count_direction,
    input wire counter_clear_high,
    input wire counter_load_low,
    output reg [15:0] count_r
);
    initial count_r = 16'h0000;
    // steps on the end of each low pulse; clear and load are async and win
    always @(posedge count_clock or posedge counter_clear_high or negedge counter_load_low) begin
        if (counter_clear_high || !counter_load_low) begin
            count_r <= 16'h0000;
        end else if (count_direction) begin
            count_r <= count_r - 16'h0001;
        end else begin
            count_r <= count_r + 16'h0001;
        end
    end
endmodule

// ### tb/tb.sv
/* self-checking bench of iom_top with an external counter model.
   assumes the 5 ns clock; step inputs run on a 64 ns link clock. */
`timescale 1ns/1ps
module tb;
    localparam [31:0] Z = 32'h0000_0000;
    reg sys_clk = 1'h0, rst_b = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
    reg [7:0] reg_addr = 8'h00;
    reg [31:0] reg_wdata = 32'h0000_0000;
    reg step_up = 1'h0, step_dn = 1'h0, quad_a = 1'h0, quad_b = 1'h0, fault_in = 1'h0;
    reg index_masked = 1'h0, raw_index_signal = 1'h0, index_enable = 1'h0;
    reg [15:0] expected_lines = 16'h0000;
    reg offset_ch1_comparator = 1'h0, phase_error_comparator = 1'h0;
    reg offset_ch2_comparator = 1'h0, amplitude_error_comparator = 1'h0;
    wire [31:0] reg_rdata;
    wire irq, line_a_true_pin, line_a_comp_pin, line_b_true_pin, line_b_comp_pin;
    wire line_index_true_pin, line_index_comp_pin, fault_pin, driver_enable, midpoint_route_en;
    wire [3:0] analog_route_sel;
    wire [15:0] cnt;
    integer miscompares = 0, total_checks = 0, i, n;
    reg [3:0] m;
    reg [15:0] base;
    iom_top dut (.*);
    iom_cnt_model u_cnt (.count_clock(line_b_true_pin), .count_direction(line_b_comp_pin),
        .counter_clear_high(line_index_true_pin), .counter_load_low(line_index_comp_pin),
        .count_r(cnt));
    // ------------------------
    // clock and tasks
    // ------------------------
    always #2.5 sys_clk = ~sys_clk;
    task chk(input [8*10-1:0] nm, input [31:0] seen, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                miscompares = miscompares + 1;
                $display("mismatch %0s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task cyc(input integer k);
        repeat (k) @(posedge sys_clk);
    endtask
    // one-cycle write, then an idle edge so the strobe is never re-driven at once
    task wr(input [7:0] a, input [31:0] d);
        begin
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= 1'h1;
            cyc(1);
            reg_wr <= 1'h0;
            cyc(1);
        end
    endtask
    // read data stand only in the cycle after the strobe
    task rd(input [8*10-1:0] nm, input [7:0] a, input [31:0] exp);
        begin
            reg_addr <= a;
            reg_rd <= 1'h1;
            cyc(1);
            reg_rd <= 1'h0;
            #1;
            chk(nm, reg_rdata, exp);
            cyc(1);
        end
    endtask
    // link steps off the clock grid; 64 ns apart, wider than pulse plus gap
    task burst(input up, input integer k);
        begin
            #1.3;
            repeat (k) begin
                if (up) step_up = 1'h1;
                else step_dn = 1'h1;
                #32;
                step_up = 1'h0;
                step_dn = 1'h0;
                #32;
            end
            cyc(20);
        end
    endtask
    task idx_pulse;
        begin
            raw_index_signal <= 1'h1;
            cyc(6);
            chk("raw index", line_index_true_pin, 1'h1);
            raw_index_signal <= 1'h0;
            cyc(8);
        end
    endtask
    task wrap_up;
        begin
            $display("checks %0d mismatches %0d", total_checks, miscompares);
            if (miscompares == 0 && total_checks > 0) begin
                $display("TEST PASSED");
            end else begin
                $display("TEST FAILED");
            end
            $finish;
        end
    endtask
    // ------------------------
    // main sequence
    // ------------------------
    initial begin
        cyc(10);
        rst_b <= 1'h1;
        cyc(1);
        rd("mode", 8'h00, Z);
        rd("cfg", 8'h04, 32'h0000_0010);
        rd("unmapped", 8'h14, Z);
        // every documented code, quadrature first and counter last
        for (i = 0; i < 8; i = i + 1) begin
            m = 32'hF765_21B0 >> (4 * i);
            // test 6 assumes the core's routing select already holds 0x40
            wr(8'h00, {28'h000_0000, m});
            cyc(6);
            rd("mode", 8'h00, {28'h000_0000, m});
            chk("route", analog_route_sel, m);
            chk("drv en", driver_enable, m == 4'h0 || m == 4'hF);
        end
        $display("modes done");
        wr(8'h00, 32'h0000_0002);
        wr(8'h04, 32'h0000_0003);
        cyc(6);
        chk("midpoint", midpoint_route_en, 1'h1);
        wr(8'h04, 32'h0000_0002);
        cyc(6);
        chk("midpoint", midpoint_route_en, 1'h0);
        $display("calibration done");
        wr(8'h04, Z);
        wr(8'h00, 32'h0000_000F);
        cyc(6);
        base = cnt;
        burst(1'h1, 5);
        chk("count up", cnt, base + 16'h0005);
        chk("dir", line_b_comp_pin, 1'h0);
        burst(1'h0, 3);
        chk("count dn", cnt, base + 16'h0002);
        chk("dir", line_b_comp_pin, 1'h1);
        rd("status", 8'h08, 32'h0000_0002);
        chk("irq", irq, 1'h0);
        wr(8'h0C, 32'h0000_0002);
        chk("irq", irq, 1'h1);
        wr(8'h08, 32'h0000_0002);
        chk("irq", irq, 1'h0);
        // pulse length select 2 gives three units of five cycles
        wr(8'h04, 32'h0000_0020);
        step_up <= 1'h1;
        for (n = 0; n < 20 && line_b_true_pin; n = n + 1) cyc(1);
        chk("pulse fall", n < 20, 1'h1);
        for (n = 0; n < 40 && !line_b_true_pin; n = n + 1) cyc(1);
        chk("pulse len", n, 15);
        step_up <= 1'h0;
        cyc(20);
        index_masked <= 1'h1;
        cyc(8);
        chk("clear", line_index_true_pin, 1'h1);
        chk("load", line_index_comp_pin, 1'h0);
        chk("cleared", cnt, Z);
        index_masked <= 1'h0;
        cyc(8);
        chk("clear", line_index_true_pin, 1'h0);
        chk("load", line_index_comp_pin, 1'h1);
        fault_in <= 1'h1;
        cyc(2);
        chk("fault", fault_pin, 1'h1);
        fault_in <= 1'h0;
        cyc(2);
        chk("fault", fault_pin, 1'h0);
        $display("counter mode done");
        wr(8'h04, Z);
        wr(8'h00, 32'h0000_000B);
        for (i = 0; i < 16; i = i + 1) begin
            {offset_ch1_comparator, phase_error_comparator, offset_ch2_comparator,
                amplitude_error_comparator} <= i[3:0];
            cyc(8);
            chk("cmp pins", {line_a_true_pin, line_a_comp_pin, line_b_true_pin,
                line_b_comp_pin}, i[3:0]);
        end
        expected_lines <= 16'h0004;
        index_enable <= 1'h1;
        chk("done", line_index_comp_pin, 1'h0);
        idx_pulse;
        chk("fault", fault_pin, 1'h0);
        burst(1'h1, 4);
        idx_pulse;
        chk("done", line_index_comp_pin, 1'h1);
        chk("fault", fault_pin, 1'h0);
        burst(1'h1, 3);
        idx_pulse;
        chk("fault", fault_pin, 1'h1);
        rd("status", 8'h08, 32'h0000_0007);
        rd("state", 8'h10, 32'h0000_002C);
        $display("system test done");
        wrap_up;
    end
endmodule
